// [rtl/nvm_pkg.sv]
// constants, commands and carriers for the eeprom, fuse and lock command sequencer
// assumes one system clock; all requests arrive already in that clock domain
package nvm_pkg;

    // eeprom geometry: byte index in the low address bits, page index above it
    localparam int BYTE_BITS = 5;
    localparam int PAGE_BITS = 3;
    localparam int PAGE_BYTES = 32;
    localparam int MEM_BYTES = 256;
    localparam int MEM_IDX_BITS = 8;
    localparam int ADDR_BITS = 16;
    localparam int FUSE_COUNT = 8;
    localparam int FUSE_IDX_BITS = 3;

    // command codes
    localparam logic [6:0] CMD_NOP = 7'h00;
    localparam logic [6:0] CMD_READ_FUSE = 7'h07;
    localparam logic [6:0] CMD_WRITE_LOCK = 7'h08;
    localparam logic [6:0] CMD_LOAD_BUF = 7'h33;
    localparam logic [6:0] CMD_ERASE_BUF = 7'h36;
    localparam logic [6:0] CMD_ERASE_PAGE = 7'h32;
    localparam logic [6:0] CMD_WRITE_PAGE = 7'h34;
    localparam logic [6:0] CMD_ERASE_WRITE = 7'h35;
    localparam logic [6:0] CMD_ERASE_ALL = 7'h30;
    localparam logic [6:0] CMD_READ_EE = 7'h06;

    // reset values and the unmapped debug-read value
    localparam logic [7:0] LOCK_RESET = 8'hff;
    localparam logic [7:0] ERASED_BYTE = 8'hff;
    localparam logic [7:0] UNMAPPED_BYTE = 8'h00;

    // execution lengths in system clock cycles
    localparam logic [7:0] LOCK_CYCLES = 8'h06;
    localparam logic [7:0] FUSE_CYCLES = 8'h02;
    localparam logic [7:0] BUFCLR_CYCLES = 8'h02;
    localparam logic [7:0] ERASE_CYCLES = 8'h10;
    localparam logic [7:0] WRITE_CYCLES = 8'h10;
    localparam logic [7:0] READ_CYCLES = 8'h02;
    localparam logic [7:0] MSTALL_CYCLES = 8'h03;

    // linear address map of the program/debug port bus
    localparam logic [23:0] DBG_EEPROM_BASE = 24'h100000;
    localparam logic [23:0] DBG_FUSE_BASE = 24'h200000;

    typedef struct packed {
        logic cmd_wr;
        logic addr_lo_wr;
        logic addr_hi_wr;
        logic data_wr;
        logic exec_wr;
        logic [7:0] wdata;
    } reg_write_type;

    typedef struct packed {
        logic st;
        logic ld;
        logic [ADDR_BITS-1:0] addr;
        logic [7:0] wdata;
    } mm_req_type;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [23:0] addr;
        logic [7:0] wdata;
    } dbg_req_type;

endpackage : nvm_pkg

// [rtl/nvm_eeprom_fuse_lock.sv]
// eeprom, fuse-read and lock-write command sequencer with page buffer and eeprom array
// assumes cpu register writes, mapped accesses and the debug-port bus are on mclk
`timescale 1ns/1ps
`default_nettype none

module nvm_eeprom_fuse_lock (
    input wire logic mclk,
    input wire logic rst,
    input wire nvm_pkg::reg_write_type reg_wr,
    input wire logic timed_change_protection,
    input wire logic ext_prog,
    input wire logic eeprom_mapped,
    input wire nvm_pkg::mm_req_type mm,
    input wire nvm_pkg::dbg_req_type dbg,
    input wire logic [nvm_pkg::FUSE_COUNT*8-1:0] fuse_bytes,
    output logic [6:0] command_reg,
    output logic [nvm_pkg::ADDR_BITS-1:0] address_reg,
    output logic [7:0] data_low_byte,
    output logic command_execute_bit,
    output logic [7:0] lock_bits,
    output logic flash_buffer_clear,
    output logic busy,
    output logic cpu_stall,
    output logic [7:0] mm_rdata,
    output logic [7:0] dbg_rdata
);

    typedef enum logic [3:0] {
        st_idle, st_lock, st_fuse, st_bufclr, st_erase, st_write, st_erase_all, st_read, st_mstall
    } state_type;

    state_type state_ff, nxt_state;
    logic [7:0] cnt_ff, nxt_cnt;
    logic [6:0] cmd_ff;
    logic [nvm_pkg::ADDR_BITS-1:0] addr_ff;
    logic [7:0] data_ff;
    logic exec_ff;
    logic [7:0] lock_ff;
    logic flash_clr_ff;
    logic [7:0] mm_rdata_ff;
    logic [7:0] dbg_rdata_ff;
    logic [nvm_pkg::PAGE_BYTES-1:0] tag_ff;
    logic [7:0] buf_ff [nvm_pkg::PAGE_BYTES];
    logic [7:0] mem_ff [nvm_pkg::MEM_BYTES];

    // decode
    wire idle = (state_ff == st_idle);
    wire unlocked = timed_change_protection | ext_prog;
    wire exec_go = reg_wr.exec_wr & unlocked & idle & ~exec_ff;
    wire [nvm_pkg::BYTE_BITS-1:0] reg_byte = addr_ff[nvm_pkg::BYTE_BITS-1:0];
    wire [nvm_pkg::PAGE_BITS-1:0] reg_page =
        addr_ff[nvm_pkg::BYTE_BITS +: nvm_pkg::PAGE_BITS];
    wire [nvm_pkg::MEM_IDX_BITS-1:0] reg_idx = {reg_page, reg_byte};
    wire [7:0] rd_byte = mem_ff[reg_idx];
    wire [nvm_pkg::FUSE_IDX_BITS-1:0] fuse_idx = addr_ff[nvm_pkg::FUSE_IDX_BITS-1:0];
    wire [7:0] fuse_byte = fuse_bytes[fuse_idx*8 +: 8];
    wire cnt_done = (cnt_ff == 8'h00);

    // page buffer load sources
    wire ld_by_dlow = reg_wr.data_wr & (cmd_ff == nvm_pkg::CMD_LOAD_BUF) & unlocked
        & ~eeprom_mapped & idle;
    wire ld_by_mm = mm.st & eeprom_mapped & idle & ~exec_ff;
    wire dbg_in_ee = (dbg.addr[23:nvm_pkg::MEM_IDX_BITS]
        == nvm_pkg::DBG_EEPROM_BASE[23:nvm_pkg::MEM_IDX_BITS]);
    wire dbg_in_fuse = (dbg.addr[23:nvm_pkg::FUSE_IDX_BITS]
        == nvm_pkg::DBG_FUSE_BASE[23:nvm_pkg::FUSE_IDX_BITS]);
    wire ld_by_dbg = dbg.wr & ext_prog & dbg_in_ee & idle
        & (cmd_ff == nvm_pkg::CMD_LOAD_BUF);
    wire buf_ld = ld_by_dlow | ld_by_mm | ld_by_dbg;
    wire [nvm_pkg::BYTE_BITS-1:0] buf_idx = ld_by_mm ? mm.addr[nvm_pkg::BYTE_BITS-1:0] :
        ld_by_dbg ? dbg.addr[nvm_pkg::BYTE_BITS-1:0] : reg_byte;
    wire [7:0] buf_din = ld_by_mm ? mm.wdata : ld_by_dbg ? dbg.wdata : reg_wr.wdata;
    wire lock_done = (state_ff == st_lock) & cnt_done;
    wire buf_clr = lock_done | ((state_ff == st_bufclr) & cnt_done);

    // array commits
    wire erase_commit = (state_ff == st_erase) & cnt_done;
    wire write_commit = (state_ff == st_write) & cnt_done;
    wire all_commit = (state_ff == st_erase_all) & cnt_done;

    // sequencer
    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = cnt_done ? 8'h00 : cnt_ff - 8'h01;
        unique case (state_ff)
            st_idle: begin
                if (exec_ff) begin
                    unique case (cmd_ff)
                        nvm_pkg::CMD_WRITE_LOCK: begin
                            nxt_state = st_lock;
                            nxt_cnt = nvm_pkg::LOCK_CYCLES - 8'h01;
                        end
                        nvm_pkg::CMD_READ_FUSE: begin
                            nxt_state = st_fuse;
                            nxt_cnt = nvm_pkg::FUSE_CYCLES - 8'h01;
                        end
                        nvm_pkg::CMD_ERASE_BUF: begin
                            nxt_state = st_bufclr;
                            nxt_cnt = nvm_pkg::BUFCLR_CYCLES - 8'h01;
                        end
                        nvm_pkg::CMD_ERASE_PAGE, nvm_pkg::CMD_ERASE_WRITE: begin
                            nxt_state = st_erase;
                            nxt_cnt = nvm_pkg::ERASE_CYCLES - 8'h01;
                        end
                        nvm_pkg::CMD_WRITE_PAGE: begin
                            nxt_state = st_write;
                            nxt_cnt = nvm_pkg::WRITE_CYCLES - 8'h01;
                        end
                        nvm_pkg::CMD_ERASE_ALL: begin
                            nxt_state = st_erase_all;
                            nxt_cnt = nvm_pkg::ERASE_CYCLES - 8'h01;
                        end
                        nvm_pkg::CMD_READ_EE: begin
                            if (!eeprom_mapped) begin
                                nxt_state = st_read;
                                nxt_cnt = nvm_pkg::READ_CYCLES - 8'h01;
                            end
                        end
                        default: nxt_state = st_idle;
                    endcase
                end else if (ld_by_mm) begin
                    nxt_state = st_mstall;
                    nxt_cnt = nvm_pkg::MSTALL_CYCLES - 8'h01;
                end
            end
            st_erase: begin
                if (cnt_done && cmd_ff == nvm_pkg::CMD_ERASE_WRITE) begin
                    nxt_state = st_write;
                    nxt_cnt = nvm_pkg::WRITE_CYCLES - 8'h01;
                end else if (cnt_done) begin
                    nxt_state = st_idle;
                end
            end
            st_lock, st_fuse, st_bufclr, st_write, st_erase_all, st_read, st_mstall: begin
                if (cnt_done) begin
                    nxt_state = st_idle;
                end
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            state_ff <= st_idle;
            cnt_ff <= 8'h00;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
        end
    end

    // command-execute bit: set by a protected trigger, cleared on the next cycle
    always_ff @(posedge mclk) begin
        if (rst) begin
            exec_ff <= 1'b0;
        end else begin
            exec_ff <= exec_go;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            cmd_ff <= nvm_pkg::CMD_NOP;
            addr_ff <= '0;
        end else if (idle && !exec_ff) begin
            if (reg_wr.cmd_wr) cmd_ff <= reg_wr.wdata[6:0];
            if (reg_wr.addr_lo_wr) addr_ff[7:0] <= reg_wr.wdata;
            if (reg_wr.addr_hi_wr) addr_ff[15:8] <= reg_wr.wdata;
        end
    end

    // data low byte: cpu writes, read and fuse results
    always_ff @(posedge mclk) begin
        if (rst) begin
            data_ff <= 8'h00;
        end else if ((state_ff == st_read) && cnt_done) begin
            data_ff <= rd_byte;
        end else if ((state_ff == st_fuse) && cnt_done) begin
            data_ff <= fuse_byte;
        end else if (reg_wr.data_wr && idle) begin
            data_ff <= reg_wr.wdata;
        end
    end

    // lock bits only move toward more protection
    always_ff @(posedge mclk) begin
        if (rst) begin
            lock_ff <= nvm_pkg::LOCK_RESET;
            flash_clr_ff <= 1'b0;
        end else begin
            flash_clr_ff <= lock_done;
            if (lock_done) lock_ff <= lock_ff & data_ff;
        end
    end

    // page buffer entries with load tags
    genvar gi;
    generate
        for (gi = 0; gi < nvm_pkg::PAGE_BYTES; gi++) begin : g_buf
            localparam logic [nvm_pkg::BYTE_BITS-1:0] ENTRY = (nvm_pkg::BYTE_BITS)'(gi);
            always_ff @(posedge mclk) begin
                if (rst || buf_clr) begin
                    tag_ff[gi] <= 1'b0;
                    buf_ff[gi] <= 8'h00;
                end else if (buf_ld && buf_idx == ENTRY) begin
                    tag_ff[gi] <= 1'b1;
                    buf_ff[gi] <= buf_din;
                end
            end
        end
        // eeprom array; only tagged positions change
        for (gi = 0; gi < nvm_pkg::MEM_BYTES; gi++) begin : g_mem
            localparam logic [nvm_pkg::MEM_IDX_BITS-1:0] CELL = (nvm_pkg::MEM_IDX_BITS)'(gi);
            localparam logic [nvm_pkg::BYTE_BITS-1:0] POS = CELL[nvm_pkg::BYTE_BITS-1:0];
            localparam logic [nvm_pkg::PAGE_BITS-1:0] PG =
                CELL[nvm_pkg::MEM_IDX_BITS-1:nvm_pkg::BYTE_BITS];
            wire hit = tag_ff[POS] & (PG == reg_page);
            always_ff @(posedge mclk) begin
                if (rst) begin
                    mem_ff[gi] <= nvm_pkg::ERASED_BYTE;
                end else if ((erase_commit && hit) || (all_commit && tag_ff[POS])) begin
                    mem_ff[gi] <= nvm_pkg::ERASED_BYTE;
                end else if (write_commit && hit) begin
                    mem_ff[gi] <= buf_ff[POS];
                end
            end
        end
    endgenerate

    // mapped loads and debug-port reads
    always_ff @(posedge mclk) begin
        if (rst) begin
            mm_rdata_ff <= 8'h00;
            dbg_rdata_ff <= 8'h00;
        end else begin
            if (mm.ld && eeprom_mapped) begin
                mm_rdata_ff <= mem_ff[mm.addr[nvm_pkg::MEM_IDX_BITS-1:0]];
            end
            if (dbg.rd && ext_prog) begin
                dbg_rdata_ff <= dbg_in_ee ? mem_ff[dbg.addr[nvm_pkg::MEM_IDX_BITS-1:0]] :
                    dbg_in_fuse ? fuse_bytes[dbg.addr[nvm_pkg::FUSE_IDX_BITS-1:0]*8 +: 8] :
                    nvm_pkg::UNMAPPED_BYTE;
            end
        end
    end

    assign busy = (state_ff == st_lock) | (state_ff == st_fuse) | (state_ff == st_bufclr)
        | (state_ff == st_erase) | (state_ff == st_write) | (state_ff == st_erase_all);
    assign cpu_stall = (state_ff == st_lock) | (state_ff == st_fuse)
        | (state_ff == st_mstall);
    assign command_reg = cmd_ff;
    assign address_reg = addr_ff;
    assign data_low_byte = data_ff;
    assign command_execute_bit = exec_ff;
    assign lock_bits = lock_ff;
    assign flash_buffer_clear = flash_clr_ff;
    assign mm_rdata = mm_rdata_ff;
    assign dbg_rdata = dbg_rdata_ff;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    sequence s_lock_start;
        idle && exec_ff && cmd_ff == nvm_pkg::CMD_WRITE_LOCK;
    endsequence
    sequence s_lock_run;
        (busy && cpu_stall) [*6] ##1 !busy;
    endsequence

    a_lock_busy_stall: assert property (s_lock_start |=> s_lock_run)
        else $error("lock write did not hold busy and stall for its length");
    a_lock_clears_buf: assert property (lock_done |=> tag_ff == '0 && flash_buffer_clear)
        else $error("lock write left a page buffer uncleared");
    a_lock_accepted: assert property (s_lock_start |=> state_ff == st_lock)
        else $error("lock write command not accepted");
    a_fuse_result: assert property ((state_ff == st_fuse && cnt_done)
        |=> data_low_byte == $past(fuse_byte))
        else $error("fuse byte not returned in data low");
    a_mstall_three: assert property (ld_by_mm |=> cpu_stall [*3] ##1 !cpu_stall)
        else $error("mapped buffer load stall not three cycles");
    a_mapped_noload: assert property (eeprom_mapped && idle && !mm.st && !dbg.wr
        |=> tag_ff == $past(tag_ff))
        else $error("register buffer load while eeprom is mapped");
    a_data_low_loads: assert property (ld_by_dlow && !ld_by_mm && !ld_by_dbg
        |=> tag_ff[$past(reg_byte)] && buf_ff[$past(reg_byte)] == $past(reg_wr.wdata))
        else $error("data low write did not load the buffer");
    a_bufclr_busy: assert property (idle && exec_ff && cmd_ff == nvm_pkg::CMD_ERASE_BUF
        |=> busy [*2] ##1 (!busy && tag_ff == '0))
        else $error("buffer erase did not clear the buffer under busy");
    a_write_tagged: assert property (write_commit |=> $past(tag_ff[reg_byte])
        ? rd_byte == $past(buf_ff[reg_byte]) : rd_byte == $past(rd_byte))
        else $error("page write changed an untagged byte or missed a tagged one");
    a_erase_then_write: assert property (erase_commit && cmd_ff == nvm_pkg::CMD_ERASE_WRITE
        |=> state_ff == st_write && busy)
        else $error("erase and write did not continue into the write");
    a_read_byte: assert property ((state_ff == st_read && cnt_done)
        |=> data_low_byte == $past(rd_byte))
        else $error("eeprom byte read returned the wrong value");
    a_unprot_ignored: assert property (reg_wr.exec_wr && !unlocked |=> !exec_ff)
        else $error("unprotected trigger was taken");
    a_exec_clears: assert property (exec_ff |=> !exec_ff)
        else $error("command execute bit did not clear itself");

endmodule : nvm_eeprom_fuse_lock

`default_nettype wire

// [tb/cpu_prog_model.sv]
// far-side model: cpu software and debug-port master driving the sequencer
// assumes mclk from the bench; every request launched 1 ns after a rising edge
`timescale 1ns/1ps
`default_nettype none

module cpu_prog_model (
    input wire logic mclk,
    output var nvm_pkg::reg_write_type reg_wr,
    output var logic timed_change_protection,
    output var nvm_pkg::mm_req_type mm,
    output var nvm_pkg::dbg_req_type dbg
);
    initial begin
        reg_wr = '0;
        timed_change_protection = 1'b0;
        mm = '0;
        dbg = '0;
    end

    // kind: 0 command, 1 address low, 2 address high, 3 data low, 4 execute
    task automatic reg_write(input int kind, input logic [7:0] v, input logic unlock);
        @(posedge mclk);
        #1;
        reg_wr = {kind == 0, kind == 1, kind == 2, kind == 3, kind == 4, v};
        timed_change_protection = unlock;
        @(posedge mclk);
        #1;
        // released data shows the inverse, not the last value
        reg_wr = {5'h00, ~v};
        timed_change_protection = 1'b0;
    endtask : reg_write

    task automatic command(input logic [6:0] c, input logic [15:0] a, input logic unlock);
        reg_write(0, {1'b0, c}, 1'b0);
        reg_write(1, a[7:0], 1'b0);
        reg_write(2, a[15:8], 1'b0);
        reg_write(4, 8'h00, unlock);
    endtask : command

    task automatic load_byte(input logic [7:0] a, input logic [7:0] d);
        reg_write(1, a, 1'b0);
        reg_write(3, d, 1'b1);
    endtask : load_byte

    task automatic mm_access(input logic st, input logic ld, input logic [15:0] a,
                             input logic [7:0] d);
        @(posedge mclk);
        #1;
        mm = {st, ld, a, d};
        @(posedge mclk);
        #1;
        mm = {2'b00, ~a, ~d};
    endtask : mm_access

    // one debug-port transfer: a write when wr is high, otherwise a read
    task automatic dbg_access(input logic wr, input logic [23:0] a, input logic [7:0] d);
        @(posedge mclk);
        #1;
        dbg = {wr, ~wr, a, d};
        @(posedge mclk);
        #1;
        dbg = {2'b00, ~a, ~d};
    endtask : dbg_access
endmodule : cpu_prog_model

`default_nettype wire

// [tb/tb_top.sv]
// self-checking bench for the eeprom, fuse and lock command sequencer
// assumes the design asserts its own rules; the model drives all requests
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic ext_prog = 1'b0;
    logic eeprom_mapped = 1'b0;
    logic [nvm_pkg::FUSE_COUNT*8-1:0] fuse_bytes;
    nvm_pkg::reg_write_type reg_wr;
    logic timed_change_protection;
    nvm_pkg::mm_req_type mm;
    nvm_pkg::dbg_req_type dbg;
    logic [6:0] command_reg;
    logic [15:0] address_reg;
    logic [7:0] data_low_byte, lock_bits, mm_rdata, dbg_rdata;
    logic command_execute_bit, flash_buffer_clear, busy, cpu_stall;
    logic [7:0] n_busy, n_stall, n_cex, n_fbc;
    int miscompares = 0;
    int tests_run = 0;

    always #2 mclk = ~mclk;

    nvm_eeprom_fuse_lock nvm_eeprom_fuse_lock_i (.mclk(mclk), .rst(rst), .reg_wr(reg_wr),
        .timed_change_protection(timed_change_protection), .ext_prog(ext_prog),
        .eeprom_mapped(eeprom_mapped), .mm(mm), .dbg(dbg), .fuse_bytes(fuse_bytes),
        .command_reg(command_reg), .address_reg(address_reg), .data_low_byte(data_low_byte),
        .command_execute_bit(command_execute_bit), .lock_bits(lock_bits),
        .flash_buffer_clear(flash_buffer_clear), .busy(busy), .cpu_stall(cpu_stall),
        .mm_rdata(mm_rdata), .dbg_rdata(dbg_rdata));

    cpu_prog_model cpu_prog_model_i (.mclk(mclk), .reg_wr(reg_wr),
        .timed_change_protection(timed_change_protection), .mm(mm), .dbg(dbg));

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // counts cycles of each status output over a fixed span
    task automatic observe(input int cycles);
        n_busy = 8'h00;
        n_stall = 8'h00;
        n_cex = 8'h00;
        n_fbc = 8'h00;
        repeat (cycles) begin
            n_busy += {7'h00, busy};
            n_stall += {7'h00, cpu_stall};
            n_cex += {7'h00, command_execute_bit};
            n_fbc += {7'h00, flash_buffer_clear};
            @(posedge mclk);
            #1;
        end
    endtask : observe

    task automatic run(input logic [6:0] c, input logic [15:0] a, input logic [7:0] eb,
                       input logic [7:0] es);
        cpu_prog_model_i.command(c, a, 1'b1);
        observe(40);
        check("command register", {1'b0, command_reg}, {1'b0, c});
        check("address low", address_reg[7:0], a[7:0]);
        check("address high", address_reg[15:8], a[15:8]);
        check("busy cycles", n_busy, eb);
        check("stall cycles", n_stall, es);
        check("execute bit cycles", n_cex, 8'h01);
    endtask : run

    task automatic read_ee(input logic [15:0] a, input logic [7:0] exp);
        run(nvm_pkg::CMD_READ_EE, a, 8'h00, 8'h00);
        check("eeprom byte", data_low_byte, exp);
    endtask : read_ee

    task automatic print_verdict;
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : print_verdict

    initial begin
        #100000;
        miscompares++;
        print_verdict();
    end

    initial begin
        for (int i = 0; i < 8; i++) fuse_bytes[i*8 +: 8] = 8'ha0 + 8'(i);
        repeat (6) @(posedge mclk);
        #1;
        rst = 1'b0;
        check("lock reset", lock_bits, 8'hff);
        // trigger outside the unlock window must be ignored
        cpu_prog_model_i.command(nvm_pkg::CMD_ERASE_BUF, 16'h0000, 1'b0);
        observe(10);
        check("unprotected trigger", {n_cex[3:0], n_busy[3:0]}, 8'h00);
        ext_prog = 1'b1;
        cpu_prog_model_i.reg_write(4, 8'h00, 1'b0);
        observe(10);
        check("external trigger", n_busy, nvm_pkg::BUFCLR_CYCLES);
        ext_prog = 1'b0;
        cpu_prog_model_i.reg_write(0, {1'b0, nvm_pkg::CMD_LOAD_BUF}, 1'b0);
        cpu_prog_model_i.load_byte(8'h40, 8'h12);
        cpu_prog_model_i.load_byte(8'h5f, 8'h34);
        run(nvm_pkg::CMD_WRITE_PAGE, 16'h0040, nvm_pkg::WRITE_CYCLES, 8'h00);
        read_ee(16'h0040, 8'h12);
        read_ee(16'h005f, 8'h34);
        read_ee(16'h0041, 8'hff);
        run(nvm_pkg::CMD_ERASE_BUF, 16'h0000, nvm_pkg::BUFCLR_CYCLES, 8'h00);
        cpu_prog_model_i.reg_write(0, {1'b0, nvm_pkg::CMD_LOAD_BUF}, 1'b0);
        cpu_prog_model_i.load_byte(8'h01, 8'h5a);
        run(nvm_pkg::CMD_WRITE_PAGE, 16'h0040, nvm_pkg::WRITE_CYCLES, 8'h00);
        read_ee(16'h0041, 8'h5a);
        run(nvm_pkg::CMD_ERASE_PAGE, 16'h0040, nvm_pkg::ERASE_CYCLES, 8'h00);
        read_ee(16'h0041, 8'hff);
        read_ee(16'h0040, 8'h12);
        run(nvm_pkg::CMD_ERASE_WRITE, 16'h0060,
            nvm_pkg::ERASE_CYCLES + nvm_pkg::WRITE_CYCLES, 8'h00);
        read_ee(16'h0061, 8'h5a);
        run(nvm_pkg::CMD_ERASE_ALL, 16'h0000, nvm_pkg::ERASE_CYCLES, 8'h00);
        read_ee(16'h0061, 8'hff);
        read_ee(16'h0040, 8'h12);
        run(nvm_pkg::CMD_READ_FUSE, 16'h0005, nvm_pkg::FUSE_CYCLES, nvm_pkg::FUSE_CYCLES);
        check("fuse byte", data_low_byte, 8'ha5);
        // mapped mode: register path refused, store path stalls
        eeprom_mapped = 1'b1;
        cpu_prog_model_i.reg_write(0, {1'b0, nvm_pkg::CMD_LOAD_BUF}, 1'b0);
        cpu_prog_model_i.load_byte(8'h85, 8'h99);
        cpu_prog_model_i.mm_access(1'b1, 1'b0, 16'h1083, 8'h77);
        observe(8);
        check("mapped store stall", n_stall, nvm_pkg::MSTALL_CYCLES);
        cpu_prog_model_i.mm_access(1'b0, 1'b1, 16'h1040, 8'h00);
        observe(2);
        check("mapped load", mm_rdata, 8'h12);
        read_ee(16'h0040, 8'h99);
        eeprom_mapped = 1'b0;
        run(nvm_pkg::CMD_WRITE_PAGE, 16'h0080, nvm_pkg::WRITE_CYCLES, 8'h00);
        read_ee(16'h0083, 8'h77);
        read_ee(16'h0085, 8'hff);
        ext_prog = 1'b1;
        cpu_prog_model_i.dbg_access(1'b0, 24'h100083, 8'h00);
        check("linear eeprom", dbg_rdata, 8'h77);
        cpu_prog_model_i.dbg_access(1'b0, 24'h200002, 8'h00);
        check("linear fuse", dbg_rdata, 8'ha2);
        cpu_prog_model_i.dbg_access(1'b0, 24'h300000, 8'h00);
        check("linear unmapped", dbg_rdata, nvm_pkg::UNMAPPED_BYTE);
        ext_prog = 1'b0;
        cpu_prog_model_i.reg_write(3, 8'hf0, 1'b0);
        run(nvm_pkg::CMD_WRITE_LOCK, 16'h0000, nvm_pkg::LOCK_CYCLES, nvm_pkg::LOCK_CYCLES);
        check("lock value", lock_bits, 8'hf0);
        check("flash buffer clear", n_fbc, 8'h01);
        run(nvm_pkg::CMD_WRITE_PAGE, 16'h00a0, nvm_pkg::WRITE_CYCLES, 8'h00);
        read_ee(16'h00a3, 8'hff);
        cpu_prog_model_i.reg_write(3, 8'h3f, 1'b0);
        run(nvm_pkg::CMD_WRITE_LOCK, 16'h0000, nvm_pkg::LOCK_CYCLES, nvm_pkg::LOCK_CYCLES);
        check("lock raise only", lock_bits, 8'h30);
        // debug-port store into the eeprom range loads the page buffer
        ext_prog = 1'b1;
        cpu_prog_model_i.reg_write(0, {1'b0, nvm_pkg::CMD_LOAD_BUF}, 1'b0);
        cpu_prog_model_i.dbg_access(1'b1, 24'h1000c5, 8'h66);
        ext_prog = 1'b0;
        run(nvm_pkg::CMD_WRITE_PAGE, 16'h00c0, nvm_pkg::WRITE_CYCLES, 8'h00);
        read_ee(16'h00c5, 8'h66);
        print_verdict();
    end
endmodule : tb_top

`default_nettype wire
